//--- led_pwm_pkg.sv
// constants and packed carriers for the sixteen-channel grayscale pwm block
// assumes one system clock; all pin inputs arrive asynchronous to it
package led_pwm_pkg;

    localparam int NUM_CH = 16;
    localparam int GS_W = 12;
    localparam int DC_W = 6;
    localparam int GS_SR_W = 192;
    localparam int DC_SR_W = 96;
    localparam int STATUS_W = 18;

    // status field positions inside the grayscale shift register
    localparam int STATUS_LOD_MSB = 191;
    localparam int STATUS_LOD_LSB = 176;
    localparam int STATUS_TEF_BIT = 175;
    localparam int STATUS_WARN_BIT = 174;

    // counter figures
    localparam logic [11:0] GS_MAX = 12'hFFF;
    localparam logic [11:0] GS_STEP = 12'h001;
    // count standing just before the 33rd grayscale clock edge
    localparam logic [11:0] LOD_CNT_BEFORE = 12'h020;

    // reset values
    localparam logic [11:0] CNT_RST = 12'h000;
    localparam logic [5:0] DC_ZERO = 6'h00;

    // synchronised pin bundle
    typedef struct packed {
        logic sclk;
        logic grayscale_ref_clock;
        logic latch;
        logic blank;
        logic correction_select;
        logic serial_input;
        logic thermal_error_flag;
        logic warn;
        logic [15:0] det;
    } pins_t;

    localparam int PINS_W = $bits(pins_t);

    typedef struct packed {
        logic [11:0] cnt;
        logic done;
        logic [15:0] on;
        logic [15:0] forced;
        logic [15:0] open_led_detect;
        logic [191:0] gs_sr;
        logic [191:0] gs_lat;
        logic [95:0] dc_sr;
        logic [95:0] dc_lat;
        logic [95:0] cur;
        logic pending;
        logic serial_output;
    } state_t;

endpackage

//--- pin_sync.sv
// two-flop synchroniser with edge detection for a bundle of pin inputs
// assumes inputs are asynchronous; edges are found after the second flop
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
    parameter int W = 8
)
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] pin_i,
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] q1;
        logic [W-1:0] q2;
        logic [W-1:0] q3;
    } sync_t;

    sync_t st_ff;
    sync_t nxt_st;

    // q1 feeds only q2 so metastability never reaches logic
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.q1 = pin_i;
        nxt_st.q2 = st_ff.q1;
        nxt_st.q3 = st_ff.q2;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    // edges from the settled stages
    assign lvl_o = st_ff.q2;
    assign rise_o = st_ff.q2 & ~st_ff.q3;
    assign fall_o = ~st_ff.q2 & st_ff.q3;

endmodule
`default_nettype wire

//--- led_pwm_core.sv
// sixteen-channel grayscale pwm with per-channel current correction
// and status readback through the grayscale shift register
// assumes all pins are asynchronous and much slower than the system clock
// Functional notes
// - twelve-bit grayscale counter advances on each grayscale clock rise until it holds at FFF
// - blanking high clears the counter and holds it at zero
// - after blanking falls, counter increments once per grayscale clock rise up to FFF
// - nonzero channels turn on at first grayscale edge after blanking falls
// - channel stays on while count not above its value, then turns off
// - on time equals grayscale clock period times the channel value
// - blanking high forces every sink channel off
// - sink current adjustable in 64 steps by six-bit code per channel
// - current scales as code over 63; 3Fh full, 00 zero
// - status loads on first serial clock rise, select low, after latch
// - open-led bits hold result captured at 33rd grayscale edge
// - thermal bits captured at first serial clock rise after latch falls
// - lit channel below open threshold is forced off automatically
// - latch strobe rise with select low copies grayscale shift register into latch
// - select high shifts serial data msb first into correction register
// - status overwrites top 18 shift bits; the other 174 stay
// - open-led bit reads one for open led, zero when normal
`timescale 1ns/10ps
`default_nettype none
module led_pwm_core
(
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire logic SERIAL_CLOCK_I,
    input wire logic GRAYSCALE_REF_CLOCK_I,
    input wire logic LATCH_STROBE_I,
    input wire logic BLANK_I,
    input wire logic CORRECTION_SELECT_I,
    input wire logic SERIAL_INPUT_I,
    input wire logic THERMAL_ERROR_FLAG_I,
    input wire logic THERMAL_WARNING_I,
    input wire logic [15:0] OPEN_LED_DETECT_I,
    output logic [15:0] SINK_CHANNEL_O,
    output logic [95:0] CURRENT_CORRECTION_O,
    output logic SERIAL_OUTPUT_O
);

    led_pwm_pkg::pins_t pin_raw;
    led_pwm_pkg::pins_t lvl;
    led_pwm_pkg::pins_t rise;
    led_pwm_pkg::pins_t fall;
    led_pwm_pkg::state_t st_ff;
    led_pwm_pkg::state_t nxt_st;

    // grayscale value of one channel in a 192-bit latch
    function automatic logic [11:0] gv(input logic [191:0] v, input int i);
        gv = v[i*led_pwm_pkg::GS_W +: led_pwm_pkg::GS_W];
    endfunction

    // correction code of one channel in a 96-bit latch
    function automatic logic [5:0] dcv(input logic [95:0] v, input int i);
        dcv = v[i*led_pwm_pkg::DC_W +: led_pwm_pkg::DC_W];
    endfunction

    // bundle the pins so one synchroniser instance covers them all
    always_comb
    begin
        pin_raw.sclk = SERIAL_CLOCK_I;
        pin_raw.grayscale_ref_clock = GRAYSCALE_REF_CLOCK_I;
        pin_raw.latch = LATCH_STROBE_I;
        pin_raw.blank = BLANK_I;
        pin_raw.correction_select = CORRECTION_SELECT_I;
        pin_raw.serial_input = SERIAL_INPUT_I;
        pin_raw.thermal_error_flag = THERMAL_ERROR_FLAG_I;
        pin_raw.warn = THERMAL_WARNING_I;
        pin_raw.det = OPEN_LED_DETECT_I;
    end

    pin_sync #(.W(led_pwm_pkg::PINS_W)) u_sync
    (
        .sys_clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .pin_i(pin_raw),
        .lvl_o(lvl),
        .rise_o(rise),
        .fall_o(fall)
    );

    // next state: serial side first, then the pwm side
    always_comb
    begin
        logic [11:0] cnt_next;
        cnt_next = st_ff.cnt + led_pwm_pkg::GS_STEP;
        nxt_st = st_ff;
        if (rise.sclk)
        begin
            if (lvl.correction_select)
                nxt_st.dc_sr = {st_ff.dc_sr[94:0], lvl.serial_input};
            else if (st_ff.pending)
            begin
                // status replaces the top bits; lower 174 untouched
                nxt_st.gs_sr[led_pwm_pkg::STATUS_LOD_MSB:
                    led_pwm_pkg::STATUS_LOD_LSB] = st_ff.open_led_detect;
                nxt_st.gs_sr[led_pwm_pkg::STATUS_TEF_BIT] = lvl.thermal_error_flag;
                nxt_st.gs_sr[led_pwm_pkg::STATUS_WARN_BIT] = lvl.warn;
                nxt_st.pending = 1'b0;
            end
            else
                nxt_st.gs_sr = {st_ff.gs_sr[190:0], lvl.serial_input};
        end
        // arming after the clear so a coincident strobe is not lost
        if (fall.latch)
            nxt_st.pending = 1'b1;
        if (rise.latch)
        begin
            if (lvl.correction_select)
                nxt_st.dc_lat = st_ff.dc_sr;
            else
                nxt_st.gs_lat = st_ff.gs_sr;
        end
        nxt_st.serial_output = lvl.correction_select ? nxt_st.dc_sr[95] : nxt_st.gs_sr[191];

        if (lvl.blank)
        begin
            nxt_st.cnt = led_pwm_pkg::CNT_RST;
            nxt_st.done = 1'b0;
            nxt_st.on = '0;
            nxt_st.forced = '0;
        end
        else
        begin
            // a lit channel seeing an open led is latched off for the period
            nxt_st.forced = st_ff.forced | (st_ff.on & lvl.det);
            if (rise.grayscale_ref_clock)
            begin
                if (st_ff.cnt == led_pwm_pkg::LOD_CNT_BEFORE)
                    nxt_st.open_led_detect = st_ff.on & lvl.det;
                // saturate so value FFF stays on a full 4095 periods
                if (st_ff.cnt == led_pwm_pkg::GS_MAX)
                    nxt_st.done = 1'b1;
                else
                    nxt_st.cnt = cnt_next;
                for (int i = 0; i < led_pwm_pkg::NUM_CH; i++)
                begin
                    nxt_st.on[i] = !st_ff.done
                        && (st_ff.cnt != led_pwm_pkg::GS_MAX)
                        && (cnt_next <= gv(st_ff.gs_lat, i))
                        && !nxt_st.forced[i];
                end
            end
            else
                nxt_st.on = st_ff.on & ~nxt_st.forced;
        end

        // current code follows the lit state; 3Fh is full scale
        for (int i = 0; i < led_pwm_pkg::NUM_CH; i++)
        begin
            nxt_st.cur[i*led_pwm_pkg::DC_W +: led_pwm_pkg::DC_W] =
                nxt_st.on[i] ? dcv(nxt_st.dc_lat, i)
                             : led_pwm_pkg::DC_ZERO;
        end
    end

    // latches have no defined power-up content; zero is chosen here
    always_ff @(posedge SYS_CLK_I)
    begin
        if (!RSTN_I)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign SINK_CHANNEL_O = st_ff.on;
    assign CURRENT_CORRECTION_O = st_ff.cur;
    assign SERIAL_OUTPUT_O = st_ff.serial_output;

    // checks on the pwm and serial behaviour
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (!RSTN_I);

    AST_BLANK_CLEARS: assert property (
        lvl.blank |=> (st_ff.cnt == 12'h000) && (st_ff.on == 16'h0000))
        else $error("blanking did not clear counter and outputs");

    AST_COUNT_STEP: assert property (
        (!lvl.blank && rise.grayscale_ref_clock && st_ff.cnt != 12'hFFF)
        |=> st_ff.cnt == $past(st_ff.cnt) + 12'h001)
        else $error("counter did not step by one");

    AST_COUNT_HOLD: assert property (
        (!lvl.blank && !rise.grayscale_ref_clock) |=> $stable(st_ff.cnt))
        else $error("counter moved without a grayscale edge");

    AST_FIRST_EDGE_ON: assert property (
        (!lvl.blank && rise.grayscale_ref_clock && st_ff.cnt == 12'h000 && !st_ff.done
         && gv(st_ff.gs_lat, 0) != 12'h000 && !lvl.det[0]
         && !st_ff.forced[0])
        |=> st_ff.on[0])
        else $error("channel missed the first edge");

    AST_COMPARE: assert property (
        (!lvl.blank && rise.grayscale_ref_clock && !st_ff.done && st_ff.cnt != 12'hFFF
         && !lvl.det[0] && !st_ff.forced[0])
        |=> st_ff.on[0] == (st_ff.cnt <= $past(gv(st_ff.gs_lat, 0))))
        else $error("channel state disagrees with compare");

    AST_ZERO_OFF: assert property (
        (rise.grayscale_ref_clock && gv(st_ff.gs_lat, 0) == 12'h000) |=> !st_ff.on[0])
        else $error("zero value channel turned on");

    AST_OPEN_OFF: assert property (
        (!lvl.blank && st_ff.on[0] && lvl.det[0]) |=> !st_ff.on[0] [*2])
        else $error("open led channel not forced off");

    AST_LOD_CAPTURE: assert property (
        (!lvl.blank && rise.grayscale_ref_clock && st_ff.cnt == 12'h020)
        |=> st_ff.open_led_detect == $past(st_ff.on & lvl.det))
        else $error("open led result not captured at 33rd edge");

    AST_STATUS_LOAD: assert property (
        (rise.sclk && !lvl.correction_select && st_ff.pending)
        |=> st_ff.gs_sr[191:176] == $past(st_ff.open_led_detect)
            && st_ff.gs_sr[175] == $past(lvl.thermal_error_flag)
            && st_ff.gs_sr[173:0] == $past(st_ff.gs_sr[173:0]))
        else $error("status load wrong");

    AST_LATCH_XFER: assert property (
        (rise.latch && !lvl.correction_select) |=> st_ff.gs_lat == $past(st_ff.gs_sr))
        else $error("grayscale latch not loaded");

    AST_DC_SHIFT: assert property (
        (rise.sclk && lvl.correction_select)
        |=> st_ff.dc_sr == {$past(st_ff.dc_sr[94:0]), $past(lvl.serial_input)})
        else $error("correction shift wrong");

    AST_CURRENT: assert property (
        st_ff.cur[5:0] == (st_ff.on[0] ? dcv(st_ff.dc_lat, 0) : 6'h00))
        else $error("current code does not follow channel");

    COV_REACH_33: cover property (rise.grayscale_ref_clock && st_ff.cnt == 12'h020);
    COV_STATUS: cover property (rise.sclk && !lvl.correction_select && st_ff.pending);
    COV_DC_LATCH: cover property (rise.latch && lvl.correction_select);
    COV_CH_OFF: cover property (st_ff.on[0] ##1 !st_ff.on[0]);

endmodule
`default_nettype wire

//--- host_link.sv
// host controller model: serial link, grayscale clock, strobe, blanking
// assumes the bench calls its tasks just after a system clock edge
`timescale 1ns/10ps
`default_nettype none
module host_link
(
    output logic sclk_o,
    output logic grayscale_ref_clock_o,
    output logic latch_o,
    output logic sel_o,
    output logic sin_o,
    output logic blank_o
);
    // clocks stand low between frames; blanking is up from power-on
    initial
    begin
        sclk_o = 1'b0;
        grayscale_ref_clock_o = 1'b0;
        latch_o = 1'b0;
        sel_o = 1'b0;
        sin_o = 1'b0;
        blank_o = 1'b1;
    end
    // data change while the clock is low, so setup is half a period
    task automatic shift(input logic [191:0] d, input int n, input logic s);
        sel_o = s;
        for (int i = n - 1; i >= 0; i--)
        begin
            sin_o = d[i];
            #62.5 sclk_o = 1'b1;
            #62.5 sclk_o = 1'b0;
        end
        sin_o = ~sin_o; // data line is not held once the frame is over
    endtask
    // select is left alone well past the strobe rise
    task automatic strobe();
        #62.5 latch_o = 1'b1;
        #62.5 latch_o = 1'b0;
        #125;
    endtask
    task automatic gs_pulse();
        grayscale_ref_clock_o = 1'b1;
        #62.5 grayscale_ref_clock_o = 1'b0;
        #62.5;
    endtask
    // blanking is set directly; nothing checks that both latches hold written data
    task automatic set_blank(input logic b);
        blank_o = b;
    endtask
endmodule
`default_nettype wire

//--- led_grayscale_pwm_dot_correction_bench.sv
// self-checking bench for the grayscale pwm block with a host model
// assumes expectations come only from the written data, the count and the driven open-led and thermal inputs
`timescale 1ns/10ps
`default_nettype none
module led_grayscale_pwm_dot_correction_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic thermal_error_flag = 1'b0;
    logic warn = 1'b0;
    logic [15:0] det = 16'h0000;
    logic sclk, grayscale_ref_clock, latch, sel, serial_input, blank, serial_output;
    logic [15:0] sink;
    logic [95:0] cur;
    int miscompares = 0;
    int checked = 0;
    int seed = 32'hed9051ed;
    logic [191:0] gsw;
    logic [191:0] stat;
    logic [95:0] dcw;
    logic [15:0] forced = 16'h0000;

    always #5 sys_clk = ~sys_clk;

    host_link u_host (.sclk_o(sclk), .grayscale_ref_clock_o(grayscale_ref_clock), .latch_o(latch),
        .sel_o(sel), .sin_o(serial_input), .blank_o(blank));
    led_pwm_core u_dut (.SYS_CLK_I(sys_clk), .RSTN_I(rstn),
        .SERIAL_CLOCK_I(sclk), .GRAYSCALE_REF_CLOCK_I(grayscale_ref_clock),
        .LATCH_STROBE_I(latch), .BLANK_I(blank),
        .CORRECTION_SELECT_I(sel), .SERIAL_INPUT_I(serial_input),
        .THERMAL_ERROR_FLAG_I(thermal_error_flag), .THERMAL_WARNING_I(warn),
        .OPEN_LED_DETECT_I(det), .SINK_CHANNEL_O(sink),
        .CURRENT_CORRECTION_O(cur), .SERIAL_OUTPUT_O(serial_output));

    task automatic sync();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic judge(input bit ok, input logic [95:0] g, e);
        checked++;
        if (!ok)
        begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_sink(input logic [15:0] g, input logic [15:0] e);
        judge(g === e, {80'h0, g}, {80'h0, e});
    endtask
    task automatic cmp_cur(input logic [95:0] g, input logic [95:0] e);
        judge(g === e, g, e);
    endtask
    task automatic cmp_serial_output(input logic g, input logic e);
        judge(g === e, {95'h0, g}, {95'h0, e});
    endtask
    // on while 0 < count <= value and not forced off by open detection
    function automatic logic [111:0] model(input int cnt);
        logic [15:0] s;
        logic [95:0] c;
        s = 16'h0000;
        c = 96'h0;
        for (int i = 0; i < 16; i++)
            if (cnt > 0 && cnt <= gsw[12*i +: 12] && !forced[i])
            begin
                s[i] = 1'b1;
                c[6*i +: 6] = dcw[6*i +: 6];
            end
        return {s, c};
    endfunction
    task automatic check_at(input int cnt);
        logic [111:0] e;
        e = model(cnt);
        cmp_sink(sink, e[111:96]);
        cmp_cur(cur, e[95:0]);
    endtask

    // watchdog: the whole sequence needs well under this bound
    initial
    begin
        #300000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1 rstn = 1'b1;
        repeat (4) sync();
        dcw = {$random(seed), $random(seed), $random(seed)};
        dcw[11:0] = 12'h03F; // channel 0 full scale, channel 1 zero current
        u_host.shift({96'h0, dcw}, 96, 1'b1);
        u_host.strobe();
        for (int i = 0; i < 16; i++)
            gsw[12*i +: 12] = {6'h00, 6'($random(seed))};
        gsw[47:0] = {12'h100, 12'h03F, 12'h000, 12'h001};
        // the first clock after a strobe loads status instead of shifting
        u_host.shift(192'h0, 1, 1'b0);
        // let an edge pass so the data line is not driven twice at once
        sync();
        u_host.shift(gsw, 192, 1'b0);
        u_host.strobe();
        sync();
        check_at(0);
        $display("test load done");
        u_host.set_blank(1'b0);
        sync();
        for (int e = 1; e <= 70; e++)
        begin
            if (e == 33)
                det[3] = 1'b1; // open led seen together with the 33rd edge
            u_host.gs_pulse();
            sync();
            if (e == 33)
                forced[3] = 1'b1;
            check_at(e);
        end
        $display("test display period done");
        u_host.set_blank(1'b1);
        det = 16'h0000;
        u_host.gs_pulse();
        repeat (6) sync();
        forced = 16'h0000;
        check_at(0);
        u_host.set_blank(1'b0);
        sync();
        u_host.gs_pulse();
        sync();
        check_at(1);
        $display("test blanking done");
        u_host.set_blank(1'b1);
        u_host.strobe();
        {thermal_error_flag, warn} = 2'($random(seed));
        stat = {16'h0008, thermal_error_flag, warn, gsw[173:0]};
        for (int i = 191; i >= 0; i--)
        begin
            u_host.shift(192'h0, 1, 1'b0);
            sync();
            cmp_serial_output(serial_output, stat[i]);
        end
        $display("test status readback done");
        end_sim();
    end
endmodule
`default_nettype wire
